//--- src/tps_sequencer.sv
`timescale 1ns/1ps
`include "tps_defs.svh"

// Functional notes
// - load: tension reels, run forward to start marker, stop
// - rewind press away from start marker rewinds to the marker
// - rewind press at start marker unloads slowly with slack
// - unload stops all three motors once take-up reel is empty
// - every rewind press drops the on-line state
// - on/off-line press goes on line in any state but slack and unload, lamp at once
// - on/off-line press while on line goes off line at once
// - on/off-line press during loading is accepted and honoured
// - controller off-line command clears on-line state and lamp
// - permanent on line: go on line at start marker, ignore button unless load held
// - supply reel running empty halts all motion at once
// - load and rewind held together: tension, then rewind
// - on/off-line while load held: tension in place, then on line
// - jumper picks density source: panel button or interface line
// - high-density lamp lit whenever the higher density is active
// - ring lamp follows write ring; no ring blocks writing
// - power lamp while powered; each power press toggles power
module tps_sequencer #(
   parameter int unsigned DEBOUNCE_CYC = `TPS_DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // front panel and transport pins
   input  wire tps_pkg::tps_buttons_t buttons,
   input  wire tps_pkg::tps_sense_t   sense,
   // motor commands and indicators
   output tps_pkg::tps_motor_t        motor,
   output tps_pkg::tps_panel_t        panel,
   output logic                       online,
   // interrupt
   output logic                       irq
);

   typedef struct packed {
      tps_pkg::tps_sense_t         s1;
      tps_pkg::tps_sense_t         s2;
      logic                        offc_d;
      tps_pkg::tps_state_t         st;
      tps_pkg::tps_target_t        tgt;
      logic                        power;
      logic                        online;
      logic                        dens_panel;
      tps_pkg::tps_motor_t         motor;
      tps_pkg::tps_panel_t         panel;
      logic [`TPS_IRQ_W-1:0]       irq_stat;
      logic [`TPS_IRQ_W-1:0]       irq_mask;
      logic                        irq;
      logic                        btn_en;
      logic                        wr_pend;
      logic [`TPS_ADDR_W-1:0]      wr_addr;
      logic [31:0]                 rdata;
   } tps_seq_regs_t;

   tps_seq_regs_t          r_r;
   tps_seq_regs_t          r_nxt;
   logic [`TPS_BTN_N-1:0]  db_level;
   logic [`TPS_BTN_N-1:0]  db_press;

   // debounced pushbuttons
   // one event per press
   tps_debounce #(
      .N   (`TPS_BTN_N),
      .CYC (DEBOUNCE_CYC)
   ) u_debounce (
      .hclk    (hclk),
      .hresetn (hresetn),
      .raw     (buttons),
      .level   (db_level),
      .press   (db_press)
   );

   // next-state logic for the whole block
   always_comb begin
      tps_pkg::tps_buttons_t   pr;
      tps_pkg::tps_buttons_t   lv;
      logic [`TPS_IRQ_W-1:0]   ev;
      logic [`TPS_IRQ_W-1:0]   w1c;
      logic                    acc;
      logic                    was_online;
      logic                    offc_edge;
      logic                    moving;
      pr         = '0;
      lv         = '0;
      ev         = '0;
      w1c        = '0;
      acc        = 1'b0;
      was_online = r_r.online;
      offc_edge  = 1'b0;
      moving     = 1'b0;
      r_nxt      = r_r;

      // pin synchronisers
      r_nxt.s1     = sense;
      r_nxt.s2     = r_r.s1;
      r_nxt.offc_d = r_r.s2.remote_offline;
      offc_edge    = r_r.s2.remote_offline & ~r_r.offc_d;

      // buttons gated by the software enable
      pr = tps_pkg::tps_buttons_t'(db_press & {`TPS_BTN_N{r_r.btn_en}});
      lv = tps_pkg::tps_buttons_t'(db_level & {`TPS_BTN_N{r_r.btn_en}});

      if (pr.power) begin
         r_nxt.power = ~r_r.power;
      end

      if (pr.density) begin
         r_nxt.dens_panel = ~r_r.dens_panel;
      end

      moving = (r_r.st == tps_pkg::ST_SEEK) ||
               (r_r.st == tps_pkg::ST_REWIND) ||
               (r_r.st == tps_pkg::ST_UNLOAD);

      // motion sequencer
      case (r_r.st)
         tps_pkg::ST_SLACK: begin
            if (lv.load && pr.online) begin
               r_nxt.st  = tps_pkg::ST_TENSION;
               r_nxt.tgt = tps_pkg::TG_HERE;
            end else if ((pr.load && lv.rewind) ||
                         (pr.rewind && lv.load)) begin
               r_nxt.st  = tps_pkg::ST_TENSION;
               r_nxt.tgt = tps_pkg::TG_REWIND;
            end else if (pr.load && !lv.rewind) begin
               r_nxt.st  = tps_pkg::ST_TENSION;
               r_nxt.tgt = tps_pkg::TG_SEEK;
            end
         end
         tps_pkg::ST_TENSION: begin
            if (r_r.s2.arms_tensioned) begin
               case (r_r.tgt)
                  tps_pkg::TG_REWIND: r_nxt.st = tps_pkg::ST_REWIND;
                  tps_pkg::TG_HERE: begin
                     r_nxt.st     = tps_pkg::ST_READY;
                     r_nxt.online = 1'b1;
                  end
                  default: r_nxt.st = tps_pkg::ST_SEEK;
               endcase
            end
         end
         tps_pkg::ST_SEEK: begin
            if (r_r.s2.tape_start_marker) begin
               r_nxt.st = tps_pkg::ST_READY;
               ev[`TPS_IRQ_AT_MARK] = 1'b1;
            end
         end
         tps_pkg::ST_READY: begin
            if (pr.rewind) begin
               if (r_r.s2.tape_start_marker) begin
                  r_nxt.st = tps_pkg::ST_UNLOAD;
               end else begin
                  r_nxt.st = tps_pkg::ST_REWIND;
               end
            end
         end
         tps_pkg::ST_REWIND: begin
            if (r_r.s2.tape_start_marker) begin
               r_nxt.st = tps_pkg::ST_READY;
               ev[`TPS_IRQ_AT_MARK] = 1'b1;
            end
         end
         tps_pkg::ST_UNLOAD: begin
            if (r_r.s2.takeup_empty) begin
               r_nxt.st = tps_pkg::ST_SLACK;
               ev[`TPS_IRQ_UNLOADED] = 1'b1;
            end
         end
         default: r_nxt.st = tps_pkg::ST_SLACK;
      endcase

      if (moving && r_r.s2.supply_empty) begin
         r_nxt.st = tps_pkg::ST_SLACK;
         ev[`TPS_IRQ_RUNOUT] = 1'b1;
      end

      if (r_r.s2.perm_online && ev[`TPS_IRQ_AT_MARK]) begin
         r_nxt.online = 1'b1;
      end

      if (pr.online && !lv.load && !r_r.s2.perm_online) begin
         if (r_r.online) begin
            r_nxt.online = 1'b0;
         end else if (r_r.st != tps_pkg::ST_SLACK &&
                      r_r.st != tps_pkg::ST_UNLOAD) begin
            r_nxt.online = 1'b1;
         end
      end

      if (pr.rewind) begin
         r_nxt.online = 1'b0;
      end

      if (offc_edge) begin
         r_nxt.online = 1'b0;
         ev[`TPS_IRQ_REMOTE_OFF] = 1'b1;
      end

      // powered down: unloaded, off line
      if (!r_nxt.power) begin
         r_nxt.st     = tps_pkg::ST_SLACK;
         r_nxt.online = 1'b0;
      end
      ev[`TPS_IRQ_ONLINE_CHG] = r_nxt.online ^ was_online;

      // motor commands from the coming state
      r_nxt.motor = '0;
      case (r_nxt.st)
         tps_pkg::ST_TENSION: r_nxt.motor.tension = 1'b1;
         tps_pkg::ST_SEEK: begin
            r_nxt.motor.tension     = 1'b1;
            r_nxt.motor.capstan_fwd = 1'b1;
         end
         tps_pkg::ST_READY: r_nxt.motor.tension = 1'b1;
         tps_pkg::ST_REWIND: begin
            r_nxt.motor.tension     = 1'b1;
            r_nxt.motor.rewind_fast = 1'b1;
         end
         tps_pkg::ST_UNLOAD: begin
            r_nxt.motor.unload_slow = 1'b1;
            r_nxt.motor.slack_allow = 1'b1;
         end
         default: r_nxt.motor = '0;
      endcase

      // indicators
      // power lamp
      r_nxt.panel.power_ind  = r_nxt.power;
      r_nxt.panel.online_ind = r_nxt.online;
      r_nxt.panel.ring_ind     = r_r.s2.write_ring & r_nxt.power;
      r_nxt.panel.write_enable = r_r.s2.write_ring & r_nxt.power;
      r_nxt.panel.hi_dens_ind  = r_nxt.power & r_r.s2.dual_density &
                                 (r_r.s2.density_from_panel ?
                                  r_nxt.dens_panel :
                                  r_r.s2.density_select_line);

      // ahb address phase
      acc = hsel & htrans[1] & hready;
      r_nxt.wr_pend = acc & hwrite;
      r_nxt.wr_addr = haddr[`TPS_ADDR_W-1:0];

      // ahb data phase of a write
      if (r_r.wr_pend) begin
         case (r_r.wr_addr)
            `TPS_OFS_CTRL:
               r_nxt.btn_en = hwdata[`TPS_CTRL_BTN_EN];
            `TPS_OFS_IRQ_STAT:
               w1c = hwdata[`TPS_IRQ_W-1:0];
            `TPS_OFS_IRQ_MASK:
               r_nxt.irq_mask = hwdata[`TPS_IRQ_W-1:0];
            default: w1c = '0;
         endcase
      end

      // sticky events, a new event beats the clear
      r_nxt.irq_stat = (r_r.irq_stat & ~w1c) | ev;
      r_nxt.irq      = |(r_nxt.irq_stat & r_nxt.irq_mask);

      // read data captured in the address phase
      if (acc && !hwrite) begin
         r_nxt.rdata = '0;
         case (haddr[`TPS_ADDR_W-1:0])
            `TPS_OFS_CTRL:
               r_nxt.rdata[`TPS_CTRL_BTN_EN] = r_r.btn_en;
            `TPS_OFS_STATUS: begin
               r_nxt.rdata[`TPS_ST_STATE_LSB +: 3] = r_r.st;
               r_nxt.rdata[`TPS_ST_ONLINE]  = r_r.online;
               r_nxt.rdata[`TPS_ST_POWER]   = r_r.power;
               r_nxt.rdata[`TPS_ST_HI_DENS] = r_r.panel.hi_dens_ind;
               r_nxt.rdata[`TPS_ST_RING]    = r_r.panel.ring_ind;
               r_nxt.rdata[`TPS_ST_AT_MARK] = r_r.s2.tape_start_marker;
            end
            `TPS_OFS_IRQ_STAT:
               r_nxt.rdata[`TPS_IRQ_W-1:0] = r_r.irq_stat;
            `TPS_OFS_IRQ_MASK:
               r_nxt.rdata[`TPS_IRQ_W-1:0] = r_r.irq_mask;
            default: r_nxt.rdata = '0;
         endcase
      end
   end

   // state registers
   // reset to unloaded, off line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_r          <= '0;
         r_r.st       <= tps_pkg::ST_SLACK;
         r_r.tgt      <= tps_pkg::TG_SEEK;
         r_r.btn_en   <= `TPS_CTRL_RST;
         r_r.irq_mask <= `TPS_IRQ_MASK_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // outputs
   assign hrdata    = r_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign motor     = r_r.motor;
   assign panel     = r_r.panel;
   assign online    = r_r.online;
   assign irq       = r_r.irq;

endmodule

//--- src/tps_defs.svh
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

// clock and debounce timing
`define TPS_CLK_MHZ        125
`define TPS_DEBOUNCE_US    5000
`define TPS_DEBOUNCE_CYC   (`TPS_DEBOUNCE_US * `TPS_CLK_MHZ)
`define TPS_DB_CNT_W       20

// pushbutton count
`define TPS_BTN_N          5

// register byte offsets, decoded on haddr[11:0]
`define TPS_ADDR_W         12
`define TPS_OFS_CTRL       12'h000
`define TPS_OFS_STATUS     12'h004
`define TPS_OFS_IRQ_STAT   12'h008
`define TPS_OFS_IRQ_MASK   12'h00c

// control register fields and reset values
`define TPS_CTRL_BTN_EN    0
`define TPS_CTRL_RST       1'b1
`define TPS_IRQ_MASK_RST   5'h00

// status register fields
`define TPS_ST_STATE_LSB   0
`define TPS_ST_ONLINE      3
`define TPS_ST_POWER       4
`define TPS_ST_HI_DENS     5
`define TPS_ST_RING        6
`define TPS_ST_AT_MARK     7

// interrupt status and mask fields
`define TPS_IRQ_W          5
`define TPS_IRQ_AT_MARK    0
`define TPS_IRQ_UNLOADED   1
`define TPS_IRQ_RUNOUT     2
`define TPS_IRQ_ONLINE_CHG 3
`define TPS_IRQ_REMOTE_OFF 4

`endif

//--- src/tps_pkg.sv
package tps_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_SLACK   = 3'b000,
      ST_TENSION = 3'b001,
      ST_SEEK    = 3'b010,
      ST_READY   = 3'b011,
      ST_REWIND  = 3'b100,
      ST_UNLOAD  = 3'b101
   } tps_state_t;

   // what follows once the arms are tensioned
   typedef enum logic [1:0] {
      TG_SEEK   = 2'b00,
      TG_REWIND = 2'b01,
      TG_HERE   = 2'b10
   } tps_target_t;

   // front-panel pushbuttons, high while pressed
   typedef struct packed {
      logic density;
      logic online;
      logic rewind;
      logic load;
      logic power;
   } tps_buttons_t;

   // sensors, straps and interface lines, all asynchronous
   typedef struct packed {
      logic tape_start_marker;
      logic supply_empty;
      logic takeup_empty;
      logic arms_tensioned;
      logic write_ring;
      logic density_select_line;
      logic remote_offline;
      logic perm_online;
      logic density_from_panel;
      logic dual_density;
   } tps_sense_t;

   // motor commands to the servo electronics
   typedef struct packed {
      logic tension;
      logic capstan_fwd;
      logic rewind_fast;
      logic unload_slow;
      logic slack_allow;
   } tps_motor_t;

   // indicators and write permission
   typedef struct packed {
      logic power_ind;
      logic online_ind;
      logic ring_ind;
      logic hi_dens_ind;
      logic write_enable;
   } tps_panel_t;

endpackage

//--- src/tps_debounce.sv
`timescale 1ns/1ps
`include "tps_defs.svh"

module tps_debounce #(
   parameter int unsigned N   = 5,
   parameter int unsigned CYC = 625000
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // raw switch levels
   input  wire logic [N-1:0] raw,
   // clean levels and press pulses
   output logic      [N-1:0] level,
   output logic      [N-1:0] press
);

   typedef struct packed {
      logic [N-1:0]                       s1;
      logic [N-1:0]                       s2;
      logic [N-1:0]                       stable;
      logic [N-1:0]                       press;
      logic [N-1:0][`TPS_DB_CNT_W-1:0]    cnt;
   } tps_db_regs_t;

   localparam logic [`TPS_DB_CNT_W-1:0] CNT_MAX =
      `TPS_DB_CNT_W'(CYC - 1);

   tps_db_regs_t r_r;
   tps_db_regs_t r_nxt;

   // per-button sync, settle timer and press edge
   always_comb begin
      r_nxt       = r_r;
      r_nxt.s1    = raw;
      r_nxt.s2    = r_r.s1;
      r_nxt.press = '0;
      for (int i = 0; i < N; i++) begin
         if (r_r.s2[i] == r_r.stable[i]) begin
            r_nxt.cnt[i] = '0;
         end else if (r_r.cnt[i] >= CNT_MAX) begin
            r_nxt.cnt[i]    = '0;
            r_nxt.stable[i] = r_r.s2[i];
            r_nxt.press[i]  = r_r.s2[i];
         end else begin
            r_nxt.cnt[i] = r_r.cnt[i] + `TPS_DB_CNT_W'(1);
         end
      end
   end

   // state registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign level = r_r.stable;
   assign press = r_r.press;

endmodule

//--- testbench/tps_seq_props.sv
`timescale 1ns/1ps
module tps_seq_props (
   // clock and reset
   input wire logic                hclk,
   input wire logic                hresetn,
   // bus answer
   input wire logic                hreadyout,
   input wire logic                hresp,
   // transport side
   input wire tps_pkg::tps_sense_t sense,
   input wire tps_pkg::tps_motor_t motor,
   input wire tps_pkg::tps_panel_t panel,
   input wire logic                online
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // supply reel seen empty, then no tape motion
   sequence s_runout;
      sense.supply_empty [*6];
   endsequence
   sequence s_halted;
      motor[3:1] == 3'h0;
   endsequence
   // take-up reel runs empty during a slow unload
   sequence s_unloaded;
      motor.unload_slow && $rose(sense.takeup_empty);
   endsequence

   // bus always ready and okay
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_power_idle: assert property (
      !panel.power_ind [*3] |-> !online && motor == 5'h00)
      else $error("activity while power off");
   a_write_power: assert property (
      panel.write_enable |-> panel.power_ind && panel.ring_ind)
      else $error("write enabled without ring or power");
   a_unload_slack: assert property (
      motor.unload_slow |-> motor.slack_allow && !motor.rewind_fast)
      else $error("unload without slack");
   a_seek_tension: assert property (
      motor.capstan_fwd |-> motor.tension && !motor.rewind_fast)
      else $error("capstan running without tension");
   a_runout_halt: assert property (s_runout |-> s_halted)
      else $error("motion after supply reel empty");
   a_remote_drop: assert property (
      $rose(sense.remote_offline) |-> ##[1:6] !online)
      else $error("remote off line not honoured");
   a_online_lamp: assert property (
      online == panel.online_ind && (!online || panel.power_ind))
      else $error("on-line lamp differs from state");
   a_unload_stop: assert property (
      s_unloaded |-> ##[1:4] motor == 5'h00)
      else $error("motors still running after unload");
endmodule

bind tps_sequencer tps_seq_props u_props (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .sense(sense), .motor(motor), .panel(panel), .online(online));

//--- testbench/tps_transport_model.sv
`timescale 1ns/1ps
module tps_transport_model #(
   parameter int T_ARM = 20,
   parameter int T_RUN = 50
) (
   // clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // motor commands, operator moving tape
   input  wire tps_pkg::tps_motor_t motor,
   input  wire logic                pull_off,
   // tape sensing
   output logic                     arms,
   output logic                     marker,
   output logic                     tk_empty
);
   int n_arm;
   int n_run;
   // arms settle under tension; runs end at marker or empty reel
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         n_arm <= 0;
         n_run <= 0;
         arms <= 1'b0;
         marker <= 1'b0;
         tk_empty <= 1'b0;
      end else begin
         n_arm <= motor.tension ? n_arm + 1 : 0;
         arms <= motor.tension && n_arm >= T_ARM;
         n_run <= (motor[3:1] != 3'h0) ? n_run + 1 : 0;
         if (n_run == T_RUN && (motor.capstan_fwd || motor.rewind_fast))
            marker <= 1'b1;
         if (pull_off || motor.unload_slow)
            marker <= 1'b0;
         if (n_run == T_RUN && motor.unload_slow)
            tk_empty <= 1'b1;
         // operator rethreads before tensioning
         if (motor.tension && !motor.unload_slow)
            tk_empty <= 1'b0;
      end
   end
endmodule

//--- testbench/tps_sequencer_test.sv
`timescale 1ns/1ps
module tps_sequencer_test;
   logic                hclk, hresetn, hsel, hwrite, pull_off;
   logic [1:0]          htrans;
   logic [31:0]         haddr, hwdata, hrdata;
   logic                hreadyout, hresp, online_o, irq_o;
   logic                sup, ring, dsl, roff, perm, dpan, dual;
   logic                arms, marker, tk;
   logic [4:0]          buttons;
   tps_pkg::tps_sense_t sense;
   tps_pkg::tps_motor_t motor;
   tps_pkg::tps_panel_t panel;
   int                  fail_count, tests_run;

   // clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // design, short debounce
   tps_sequencer #(.DEBOUNCE_CYC(4)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .buttons(buttons), .sense(sense),
      .motor(motor), .panel(panel), .online(online_o),
      .irq(irq_o));
   tps_transport_model mech (.hclk(hclk), .hresetn(hresetn),
      .motor(motor), .pull_off(pull_off), .arms(arms), .marker(marker),
      .tk_empty(tk));
   assign sense = {marker, sup, tk, arms, ring, dsl, roff, perm, dpan, dual};

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // single ahb transfer, held until ready
   task automatic ahb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   // press or release, held past debounce
   task automatic btn(input logic [4:0] b, input logic on);
      buttons <= on ? (buttons | b) : (buttons & ~b);
      cyc(12);
   endtask
   task automatic tap(input logic [4:0] b);
      btn(b, 1'b1);
      btn(b, 1'b0);
   endtask
   // poll state field until match or limit
   task automatic st(input logic [2:0] s);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         ahb(1'b0, 12'h004, 32'h0, r);
         n++;
      end while (r[2:0] !== s && n < 200);
      chk(r[2:0], s);
   endtask
   task automatic pcyc();
      tap(5'h01);
      chk({online_o, motor}, 6'h00);
      tap(5'h01);
   endtask
   task automatic pull();
      pull_off <= 1'b1;
      cyc(1);
      pull_off <= 1'b0;
   endtask

   task automatic t_regs();
      rd(12'h000, 32'hffffffff, 32'h1);
      rd(12'h004, 32'hffffffff, 32'h0);
      rd(12'h00c, 32'hffffffff, 32'h0);
      wr(12'h00c, 32'h1f);
      rd(12'h00c, 32'hffffffff, 32'h1f);
      wr(12'h010, 32'h5a);
      rd(12'h010, 32'hffffffff, 32'h0);
   endtask
   task automatic t_power();
      ring <= 1'b1;
      tap(5'h01);
      chk(panel, 5'h15);
      ring <= 1'b0;
      cyc(6);
      chk(panel, 5'h10);
      ring <= 1'b1;
      tap(5'h08);
      chk(online_o, 1'b0);
   endtask
   task automatic t_load();
      wr(12'h008, 32'h1f);
      tap(5'h02);
      tap(5'h08);
      chk(online_o, 1'b1);
      st(3'h3);
      chk(motor, 5'h10);
      rd(12'h008, 32'h01, 32'h01);
      chk(irq_o, 1'b1);
      wr(12'h008, 32'h1f);
      cyc(2);
      chk(irq_o, 1'b0);
      tap(5'h08);
      chk(online_o, 1'b0);
      tap(5'h08);
      chk(online_o, 1'b1);
   endtask
   task automatic t_rewind();
      pull();
      tap(5'h04);
      chk({online_o, motor.rewind_fast}, 2'h1);
      st(3'h3);
      tap(5'h04);
      chk(motor[1:0], 2'h3);
      st(3'h0);
      chk(motor, 5'h00);
      rd(12'h008, 32'h02, 32'h02);
   endtask
   task automatic t_runout();
      tap(5'h02);
      st(3'h2);
      sup <= 1'b1;
      st(3'h0);
      rd(12'h008, 32'h04, 32'h04);
      sup <= 1'b0;
      btn(5'h06, 1'b1);
      st(3'h4);
      btn(5'h06, 1'b0);
      st(3'h3);
   endtask
   task automatic t_perm();
      pcyc();
      perm <= 1'b1;
      tap(5'h02);
      st(3'h3);
      chk(online_o, 1'b1);
      tap(5'h08);
      chk(online_o, 1'b1);
      perm <= 1'b0;
      roff <= 1'b1;
      cyc(8);
      chk(online_o, 1'b0);
      rd(12'h008, 32'h10, 32'h10);
      roff <= 1'b0;
   endtask
   task automatic t_restart();
      pcyc();
      pull();
      wr(12'h000, 32'h0);
      btn(5'h02, 1'b1);
      rd(12'h004, 32'h07, 32'h0);
      wr(12'h000, 32'h1);
      tap(5'h08);
      st(3'h3);
      chk({online_o, marker}, 2'h2);
      btn(5'h02, 1'b0);
   endtask
   task automatic t_dens();
      dual <= 1'b1;
      dpan <= 1'b1;
      tap(5'h10);
      chk(panel.hi_dens_ind, 1'b1);
      dpan <= 1'b0;
      cyc(6);
      chk(panel.hi_dens_ind, 1'b0);
      dsl <= 1'b1;
      cyc(6);
      chk(panel.hi_dens_ind, 1'b1);
   endtask

   task automatic conclude();
      if (fail_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog
   initial begin
      cyc(30000);
      fail_count++;
      conclude();
   end
   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      buttons = 5'h00;
      pull_off = 1'b0;
      {sup, ring, dsl, roff, perm, dpan, dual} = 7'h00;
      fail_count = 0;
      tests_run = 0;
      cyc(12);
      hresetn <= 1'b1;
      t_regs();
      t_power();
      t_load();
      t_rewind();
      t_runout();
      t_perm();
      t_restart();
      t_dens();
      conclude();
   end
endmodule
